// File: hdl/capture_pkg.sv
/*
  Package for the timer input capture unit: register offsets, field positions,
  reset values and enumerations shared by the design files.
  Assumes an 8-bit register port with one-cycle strobes.
*/
package capture_pkg;

  // ==========================================================================
  // Register offsets (byte port, index = address)
  localparam logic [3:0] ADDR_CTRL_FIRST = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND = 4'h1;
  localparam logic [3:0] ADDR_CNT_LOW = 4'h2;
  localparam logic [3:0] ADDR_CNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CAP_LOW = 4'h4;
  localparam logic [3:0] ADDR_CAP_HIGH = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;

  // ==========================================================================
  // Field positions
  // timer_control_first: [1:0] low waveform bits, [7] source select
  localparam int WGM_LO_POS = 0;
  localparam int SRC_SEL_POS = 7;
  // timer_control_second: [6] edge select, [5] reserved, [4:3] waveform high, [2:0] clock
  localparam int EDGE_SEL_POS = 6;
  localparam int WGM_HI_POS = 3;
  localparam int CLK_SEL_POS = 0;
  // Status and mask layout
  localparam int OVF_BIT = 0;
  localparam int CAP_BIT = 5;

  // ==========================================================================
  // Reset value, write masks and counter maximum
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SECOND_WMASK = 8'hDF;
  localparam logic [7:0] STATUS_WMASK = 8'h21;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Waveform modes where the capture register serves as TOP
  localparam logic [3:0] WGM_PFC_ICR = 4'h8;
  localparam logic [3:0] WGM_PC_ICR = 4'hA;
  localparam logic [3:0] WGM_CTC_ICR = 4'hC;
  localparam logic [3:0] WGM_FAST_ICR = 4'hE;

  // Counter direction
  typedef enum logic {count_up, count_down} dir_t;

endpackage

// File: hdl/capture_edge_detect.sv
/*
  Edge detector for the capture source: source select, edge polarity.
  Assumes both source inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module capture_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sources and settings
  input wire logic pin_level,
  input wire logic comp_level,
  input wire logic use_comparator,
  input wire logic rising_sel,
  input wire logic enable,
  // Result
  output logic trigger
);
  logic sel_level;
  logic prev_ff;

  // Source chosen afresh every clock
  assign sel_level = use_comparator ? comp_level : pin_level;

  // Previous level of the selected source
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sel_level;
    end
  end

  // Level change matching edge setting; gated when capture is disabled
  assign trigger = enable && (rising_sel ? (sel_level && !prev_ff) : (!sel_level && prev_ff));

endmodule // capture_edge_detect
`default_nettype wire

// File: hdl/capture_counter.sv
/*
  16-bit running counter with clock-select prescaler and overflow event.
  Assumes ext_tick is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module capture_counter
  import capture_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic [2:0] clk_sel,
  input wire logic [3:0] mode,
  input wire logic [WIDTH-1:0] top_value,
  input wire logic ext_tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // State
  output logic [WIDTH-1:0] count,
  output logic overflow
);
  logic [9:0] pre_ff;
  logic tick;
  logic dual_slope;
  logic at_top;
  dir_t dir_ff;

  // Prescaler turns clk into one-cycle count enables
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_ff <= 10'h000;
    end else begin
      pre_ff <= pre_ff + 10'h001;
    end
  end

  always_comb begin
    case (clk_sel)
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_ff[2:0] == 3'h7);
      3'h3: tick = (pre_ff[5:0] == 6'h3F);
      3'h4: tick = (pre_ff[7:0] == 8'hFF);
      3'h5: tick = (pre_ff == 10'h3FF);
      3'h6: tick = ext_tick;
      3'h7: tick = ext_tick;
      default: tick = 1'b0;
    endcase
  end

  // Dual-slope modes turn at TOP and flag overflow at BOTTOM
  assign dual_slope = (mode == WGM_PFC_ICR) || (mode == WGM_PC_ICR) || (mode == 4'h1) || (mode == 4'h9);
  assign at_top = (mode == WGM_CTC_ICR) || (mode == WGM_FAST_ICR) || dual_slope ? (count == top_value)
                                                                                  : (count == COUNT_MAX[WIDTH-1:0]);

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      dir_ff <= count_up;
      overflow <= 1'b0;
    end else if (load) begin
      count <= load_value;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (tick) begin
        if (dual_slope) begin
          if (dir_ff == count_up && at_top) begin
            dir_ff <= count_down;
            count <= count - 1'b1;
          end else if (dir_ff == count_down && count == '0) begin
            dir_ff <= count_up;
            count <= count + 1'b1;
            overflow <= 1'b1;
          end else begin
            count <= (dir_ff == count_up) ? count + 1'b1 : count - 1'b1;
          end
        end else if (at_top) begin
          count <= '0;
          overflow <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule // capture_counter
`default_nettype wire

// File: hdl/capture_unit.sv
/*
  Input capture unit of a 16-bit timer/counter with an 8-bit register port,
  shared high-byte shadow, sticky status flags, mask and one interrupt line.
  Assumes all inputs are synchronous to clk and strobes are one cycle long.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_input_capture_unit
  import capture_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Event sources
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  input wire logic ext_clock_tick,
  // Interrupt
  input wire logic capture_irq_ack,
  output logic irq
);

  // ==========================================================================
  // Registers
  logic [7:0] timer_control_first_ff;
  logic [7:0] timer_control_second_ff;
  logic [7:0] mask_ff;
  logic [7:0] status_ff;
  logic [WIDTH-1:0] capture_register_ff;
  logic [7:0] shadow_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] nxt_status;
  logic [7:0] nxt_mask;
  logic [3:0] waveform_mode_select;
  logic capture_enable;
  logic capture_trigger;
  logic [WIDTH-1:0] running_counter;
  logic overflow_evt;
  logic cnt_load;
  logic capture_flag;
  logic capture_irq_enable;
  logic timer_overflow_flag;

  assign waveform_mode_select = {timer_control_second_ff[WGM_HI_POS +: 2], timer_control_first_ff[WGM_LO_POS +: 2]};
  assign capture_flag = status_ff[CAP_BIT];
  assign timer_overflow_flag = status_ff[OVF_BIT];
  assign capture_irq_enable = mask_ff[CAP_BIT];

  // Capture disconnected in modes 8, A, C and E; modes 1 and 9 also use its register as TOP
  assign capture_enable = !((waveform_mode_select == WGM_PFC_ICR) || (waveform_mode_select == WGM_PC_ICR) ||
                            (waveform_mode_select == WGM_CTC_ICR) || (waveform_mode_select == WGM_FAST_ICR));

  // ==========================================================================
  // Submodules
  // Switching the source while the two levels differ looks like an edge;
  // software should clear the flag after changing the selection
  capture_edge_detect edge_i (
    .clk(clk),
    .reset(reset),
    .pin_level(capture_input_pin),
    .comp_level(comparator_output),
    .use_comparator(timer_control_first_ff[SRC_SEL_POS]),
    .rising_sel(timer_control_second_ff[EDGE_SEL_POS]),
    .enable(capture_enable),
    .trigger(capture_trigger)
  );

  // Counter writes go through the shadow: high byte staged, low byte commits
  assign cnt_load = wr && (addr == ADDR_CNT_LOW);

  capture_counter #(
    .WIDTH(WIDTH)
  ) counter_i (
    .clk(clk),
    .reset(reset),
    .clk_sel(timer_control_second_ff[CLK_SEL_POS +: 3]),
    .mode(waveform_mode_select),
    .top_value(capture_register_ff),
    .ext_tick(ext_clock_tick),
    .load(cnt_load),
    .load_value({shadow_ff, wdata}),
    .count(running_counter),
    .overflow(overflow_evt)
  );

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_control_first_ff <= CTRL_RESET;
      timer_control_second_ff <= CTRL_RESET;
      mask_ff <= CTRL_RESET;
    end else if (wr) begin
      if (addr == ADDR_CTRL_FIRST) begin
        timer_control_first_ff <= wdata;
      end
      // Reserved bit is not stored, so it always reads zero
      if (addr == ADDR_CTRL_SECOND) begin
        timer_control_second_ff <= wdata & SECOND_WMASK;
      end
      if (addr == ADDR_IRQ_MASK) begin
        mask_ff <= wdata & STATUS_WMASK;
      end
    end
  end

  // ==========================================================================
  // Capture register: software may write it only in modes 8, A, C and E
  always_ff @(posedge clk) begin
    if (reset) begin
      capture_register_ff <= '0;
    end else if (capture_trigger) begin
      capture_register_ff <= running_counter;
    end else if (wr && addr == ADDR_CAP_LOW && !capture_enable) begin
      capture_register_ff <= {shadow_ff, wdata};
    end
  end

  // ==========================================================================
  // Shared high-byte shadow
  always_ff @(posedge clk) begin
    if (reset) begin
      shadow_ff <= 8'h00;
    end else if (rd && addr == ADDR_CAP_LOW) begin
      shadow_ff <= capture_register_ff[15:8];
    end else if (rd && addr == ADDR_CNT_LOW) begin
      shadow_ff <= running_counter[15:8];
    end else if (wr && (addr == ADDR_CAP_HIGH || addr == ADDR_CNT_HIGH)) begin
      shadow_ff <= wdata;
    end
  end

  // ==========================================================================
  // Sticky status: a set in the same cycle as a clear wins
  always_comb begin
    nxt_status = status_ff;
    if (wr && addr == ADDR_IRQ_STATUS) begin
      nxt_status = nxt_status & ~(wdata & STATUS_WMASK);
    end
    if (capture_irq_ack) begin
      nxt_status[CAP_BIT] = 1'b0;
    end
    if (capture_trigger) begin
      nxt_status[CAP_BIT] = 1'b1;
    end
    if (overflow_evt) begin
      nxt_status[OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status_ff <= 8'h00;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Mask as it stands after this edge, so irq never lags a mask write
  always_comb begin
    nxt_mask = mask_ff;
    if (wr && addr == ADDR_IRQ_MASK) begin
      nxt_mask = wdata & STATUS_WMASK;
    end
  end

  // Level interrupt while any unmasked flag stands
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_status & nxt_mask);
    end
  end

  // ==========================================================================
  // Read data, valid only in the cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    case (addr)
      ADDR_CTRL_FIRST: nxt_rdata = timer_control_first_ff;
      ADDR_CTRL_SECOND: nxt_rdata = timer_control_second_ff;
      ADDR_CNT_LOW: nxt_rdata = running_counter[7:0];
      ADDR_CNT_HIGH: nxt_rdata = shadow_ff;
      ADDR_CAP_LOW: nxt_rdata = capture_register_ff[7:0];
      ADDR_CAP_HIGH: nxt_rdata = shadow_ff;
      ADDR_IRQ_MASK: nxt_rdata = mask_ff;
      ADDR_IRQ_STATUS: nxt_rdata = status_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= nxt_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Checks
  sequence low_read_s;
    rd && addr == ADDR_CAP_LOW;
  endsequence

  sequence high_read_s;
    rd && addr == ADDR_CAP_HIGH;
  endsequence

  sequence pin_rise_s;
    !$past(reset) && capture_enable && timer_control_second_ff[EDGE_SEL_POS] &&
    !timer_control_first_ff[SRC_SEL_POS] && $stable(timer_control_first_ff[SRC_SEL_POS]) &&
    $rose(capture_input_pin);
  endsequence

  sequence comp_fall_s;
    !$past(reset) && capture_enable && !timer_control_second_ff[EDGE_SEL_POS] &&
    timer_control_first_ff[SRC_SEL_POS] && $stable(timer_control_first_ff[SRC_SEL_POS]) &&
    $fell(comparator_output);
  endsequence

  capture_copy_a: assert property (@(posedge clk) disable iff (reset)
    capture_trigger |=> capture_register_ff == $past(running_counter))
    else $error("capture register missed counter value");

  flag_same_a: assert property (@(posedge clk) disable iff (reset)
    capture_trigger |=> capture_flag)
    else $error("capture flag not set with capture");

  irq_raise_a: assert property (@(posedge clk) disable iff (reset)
    (capture_flag && capture_irq_enable) |-> irq || $past(capture_trigger))
    else $error("enabled capture flag without interrupt");

  ack_clear_a: assert property (@(posedge clk) disable iff (reset)
    (capture_irq_ack && !capture_trigger) |=> !capture_flag)
    else $error("acknowledge did not clear capture flag");

  write_clear_a: assert property (@(posedge clk) disable iff (reset)
    (wr && addr == ADDR_IRQ_STATUS && !wdata[CAP_BIT] && capture_flag) |=> capture_flag)
    else $error("writing zero cleared capture flag");

  shadow_read_a: assert property (@(posedge clk) disable iff (reset)
    low_read_s ##1 high_read_s |=> rdata == $past(capture_register_ff[15:8], 2))
    else $error("high read did not return latched byte");

  shadow_out_a: assert property (@(posedge clk) disable iff (reset)
    high_read_s |=> rdata == $past(shadow_ff))
    else $error("high read bypassed the shadow");

  top_disable_a: assert property (@(posedge clk) disable iff (reset)
    (!capture_enable && !(wr && addr == ADDR_CAP_LOW)) |=> $stable(capture_register_ff) && !$rose(capture_flag))
    else $error("capture fired while register is TOP");

  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    timer_control_second_ff[5] == 1'b0)
    else $error("reserved control bit stored");

  overflow_flag_a: assert property (@(posedge clk) disable iff (reset)
    overflow_evt |=> timer_overflow_flag)
    else $error("overflow flag not set");

  // ==========================================================================
  // Capture source and edge
  pin_capture_a: assert property (@(posedge clk) disable iff (reset)
    pin_rise_s |-> capture_trigger)
    else $error("rising pin edge did not capture");

  comp_capture_a: assert property (@(posedge clk) disable iff (reset)
    comp_fall_s |-> capture_trigger)
    else $error("falling comparator edge did not capture");

  wrong_edge_a: assert property (@(posedge clk) disable iff (reset)
    capture_trigger |-> timer_control_second_ff[EDGE_SEL_POS] ==
      (timer_control_first_ff[SRC_SEL_POS] ? comparator_output : capture_input_pin))
    else $error("capture on a level that does not match the edge setting");

  // ==========================================================================
  // Flags and interrupt
  write_one_a: assert property (@(posedge clk) disable iff (reset)
    (wr && addr == ADDR_IRQ_STATUS && wdata[CAP_BIT] && !capture_trigger) |=> !capture_flag)
    else $error("writing one left capture flag set");

  ovf_write_a: assert property (@(posedge clk) disable iff (reset)
    (wr && addr == ADDR_IRQ_STATUS && wdata[OVF_BIT] && !overflow_evt) |=> !timer_overflow_flag)
    else $error("writing one left overflow flag set");

  flag_hold_a: assert property (@(posedge clk) disable iff (reset)
    (capture_flag && !capture_irq_ack && !(wr && addr == ADDR_IRQ_STATUS && wdata[CAP_BIT])) |=> capture_flag)
    else $error("capture flag dropped without a clear");

  irq_level_a: assert property (@(posedge clk) disable iff (reset)
    irq == |(status_ff & mask_ff))
    else $error("interrupt line disagrees with unmasked flags");

  // ==========================================================================
  // Register port
  low_data_a: assert property (@(posedge clk) disable iff (reset)
    low_read_s |=> rdata == $past(capture_register_ff[7:0]))
    else $error("low read returned wrong byte");

  shadow_latch_a: assert property (@(posedge clk) disable iff (reset)
    low_read_s |=> shadow_ff == $past(capture_register_ff[15:8]))
    else $error("low read did not latch high byte");

  rdata_idle_a: assert property (@(posedge clk) disable iff (reset)
    !rd |=> rdata == 8'h00)
    else $error("read data not zero without a read");

  counter_load_a: assert property (@(posedge clk) disable iff (reset)
    cnt_load |=> running_counter == $past({shadow_ff, wdata}))
    else $error("counter write did not commit staged value");

endmodule // timer_input_capture_unit
`default_nettype wire

// File: bench/event_source_model.sv
/*
  Model of the capture sources: the event pin and the comparator output.
  Assumes the bench calls drive; levels change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
  // Clock
  input wire logic clk,
  // Source levels
  output logic pin_level,
  output logic comp_level
);
  // ====================
  // Both sources idle low
  initial begin
    pin_level = 1'b0;
    comp_level = 1'b0;
  end
  // Set both levels, then hold them for gap cycles (short or slow)
  task automatic drive(input logic p, input logic c, input int gap);
    @(posedge clk);
    pin_level <= p;
    comp_level <= c;
    repeat (gap) @(posedge clk);
  endtask
endmodule // event_source_model
`default_nettype wire

// File: bench/timer_input_capture_unit_tb_top.sv
/*
  Self-checking bench for the capture unit: bus tasks, random counter values.
  Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_input_capture_unit_tb_top
  import capture_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tick = 1'b0;
  logic ack = 1'b0;
  logic pin;
  logic comp;
  logic irq;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [15:0] c;
  logic [15:0] w;
  int fails = 0;
  int total_checks = 0;
  // ====================
  // Clock, design and source model
  always #2 clk = ~clk;
  timer_input_capture_unit dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .capture_input_pin(pin), .comparator_output(comp), .ext_clock_tick(tick),
    .capture_irq_ack(ack), .irq(irq));
  event_source_model src (.clk(clk), .pin_level(pin), .comp_level(comp));
  // ====================
  // Compare tasks
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask
  // Bus tasks; the read samples in the one cycle the data stand
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Low then high with no gap, so the high byte comes from the shadow
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    addr <= a + 4'h1;
    #1 d[7:0] = rdata;
    @(posedge clk);
    rd <= 1'b0;
    #1 d[15:8] = rdata;
  endtask
  // High byte first, since the low write commits the shadow
  task automatic set_cnt(input logic [15:0] x);
    wr8(ADDR_CNT_HIGH, x[15:8]);
    wr8(ADDR_CNT_LOW, x[7:0]);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask
  // ====================
  // Expectations
  function automatic logic [7:0] ctrl2(input logic e, input logic [1:0] hi, input logic [2:0] cs);
    return {1'b0, e, 1'b0, hi, cs};
  endfunction
  function automatic logic cap_on(input logic [3:0] m);
    return !(m == WGM_PFC_ICR || m == WGM_PC_ICR || m == WGM_CTC_ICR || m == WGM_FAST_ICR);
  endfunction
  // Wrong edge and unselected source must not capture; a matching edge must unless the mode is 8, A, C or E
  task automatic edge_case(input logic s, input logic e, input logic [3:0] m, input logic [15:0] x);
    wr8(ADDR_CTRL_FIRST, {s, 5'h00, m[1:0]});
    wr8(ADDR_CTRL_SECOND, ctrl2(e, m[3:2], 3'h0));
    set_cnt(x);
    src.drive(e, e, 2);
    wr8(ADDR_IRQ_STATUS, 8'h21);
    src.drive(!e, !e, 3);
    src.drive(s ? e : !e, s ? !e : e, 3);
    rd8(ADDR_IRQ_STATUS, v);
    chk8("no capture", 8'h00, v & 8'h20);
    src.drive(e, e, 3);
    rd8(ADDR_IRQ_STATUS, v);
    chk8("capture flag", cap_on(m) ? 8'h20 : 8'h00, v & 8'h20);
    if (cap_on(m)) begin
      rd8(ADDR_CAP_LOW, v);
      chk8("capture low", x[7:0], v);
      rd8(ADDR_CAP_HIGH, v);
      chk8("capture high", x[15:8], v);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ====================
  // Watchdog, far beyond the expected run
  initial begin
    #80000;
    fails++;
    summarize();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h1469643F));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd8(4'(a), v);
      chk8("reset value", 8'h00, v);
    end
    rd8(4'h8 | 4'($urandom), v);
    chk8("unmapped", 8'h00, v);
    chk1("irq reset", 1'b0, irq);
    // Every source and edge, then modes 8, A, C and E, where capture is disconnected
    for (int i = 0; i < 4; i++) begin
      edge_case(i[0], i[1], 4'h0, 16'($urandom));
    end
    for (int k = 0; k < 4; k++) begin
      edge_case(1'($urandom), 1'($urandom), 4'(8 + 2 * k), 16'($urandom));
    end
    // Interrupt: raise, write zero, write one, acknowledge, mask off
    wr8(ADDR_IRQ_MASK, 8'h20);
    edge_case(1'b0, 1'b1, 4'h0, 16'($urandom));
    chk1("irq on flag", 1'b1, irq);
    wr8(ADDR_IRQ_STATUS, 8'h00);
    rd8(ADDR_IRQ_STATUS, v);
    chk8("write zero", 8'h20, v & 8'h20);
    wr8(ADDR_IRQ_STATUS, 8'h20);
    rd8(ADDR_IRQ_STATUS, v);
    chk8("write one", 8'h00, v & 8'h20);
    chk1("irq cleared", 1'b0, irq);
    edge_case(1'b1, 1'b0, 4'h0, 16'($urandom));
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rd8(ADDR_IRQ_STATUS, v);
    chk8("ack clear", 8'h00, v & 8'h20);
    wr8(ADDR_IRQ_MASK, 8'h00);
    edge_case(1'b0, 1'b1, 4'h0, 16'($urandom));
    chk1("irq masked", 1'b0, irq);
    // Shadow keeps the old high byte across a new capture
    c = {1'b0, 15'($urandom)};
    edge_case(1'b0, 1'b1, 4'h0, c);
    rd8(ADDR_CAP_LOW, v);
    wr8(ADDR_CTRL_SECOND, ctrl2(1'b1, 2'b00, 3'h7));
    pulse(256);
    src.drive(1'b0, 1'b0, 2);
    src.drive(1'b1, 1'b1, 3);
    rd8(ADDR_CAP_HIGH, v);
    chk8("shadow high", c[15:8], v);
    c = c + 16'h0100;
    rd16(ADDR_CAP_LOW, w);
    chk8("new low", c[7:0], w[7:0]);
    chk8("new high", c[15:8], w[15:8]);
    // Overflow at the top of the normal mode
    set_cnt(16'hFFFE);
    wr8(ADDR_IRQ_STATUS, 8'h21);
    wr8(ADDR_IRQ_MASK, 8'h01);
    pulse(3);
    rd8(ADDR_IRQ_STATUS, v);
    chk8("overflow flag", 8'h01, v & 8'h01);
    chk1("overflow irq", 1'b1, irq);
    wr8(ADDR_IRQ_STATUS, 8'h01);
    rd8(ADDR_IRQ_STATUS, v);
    chk1("overflow cleared", 1'b0, irq);
    // Undivided clock for exactly two cycles between the two writes
    set_cnt(16'h00FF);
    wr8(ADDR_CTRL_SECOND, ctrl2(1'b1, 2'b00, 3'h1));
    wr8(ADDR_CTRL_SECOND, ctrl2(1'b1, 2'b00, 3'h0));
    rd16(ADDR_CNT_LOW, w);
    chk8("count low", 8'h01, w[7:0]);
    chk8("count high", 8'h01, w[15:8]);
    summarize();
  end
endmodule // timer_input_capture_unit_tb_top
`default_nettype wire
